// ==== core/fp_add_sub_align.v ====
// Floating-point add, subtract and reverse subtract: zero test,
// exponent comparison, mantissa alignment and the operate phase.
// Assumes one synchronous clock; operands are valid with start, and held one cycle longer for reverse subtract.
`timescale 1ns/1ps
`default_nettype none
`include "fp_align_defines.vh"

// Summary of operation
// RULE1 - Reverse subtract: test A minus one, B off; all ones means A zero, skip
// RULE2 - Add or subtract: test zero minus B minus one; all ones means B zero
// RULE3 - Exponent gap above 35: set skip flag, no shifting, go operate
// RULE4 - Otherwise test exponent A minus B minus one; equal means no shifting
// RULE5 - Sign of exponent difference decides which mantissa is aligned
// RULE6 - Shift A on three sign cases, otherwise shift B
// RULE7 - Shifting A: counter loaded with minus difference, counts up to carry
// RULE8 - Shifting B: counter loaded with difference minus one, down to borrow
// RULE9 - When A is shifted, copy exponent B into exponent A
// RULE10 - Time-state generator stopped during shifting, restarted after
// RULE11 - Operate: disable ALU side whose mantissa is zero
// RULE12 - Large gap: disable ALU side of the smaller-exponent operand
// RULE13 - Effective subtract uses A minus B minus one, effective add A plus B
// RULE14 - Omit carry insert when B shifted, rounding, extension bit set
// RULE15 - Subtract overflow: complement sign, two's complement the mantissa
// RULE16 - After overflow, add one unless rounding and extension bit both set
// RULE17 - Rounding choice comes from instruction bit 14
// RULE18 - Reverse subtract moves accumulator into B side before loading
// RULE19 - Skip flag cleared at the start of every alignment phase
module fp_add_sub_align #(
  parameter FW = `FRAC_W,
  parameter EW = `SCALE_W,
  parameter CW = `CNT_W
) (
  input wire clock,
  input wire rst,
  input wire load_acc,
  input wire start,
  input wire [1:0] op,
  input wire [`INSTR_W-1:0] instr_word,
  input wire op_sign,
  input wire [EW-1:0] op_scale,
  input wire [FW-1:0] op_frac,
  output wire [FW-1:0] frac_acc_a,
  output wire [FW-1:0] frac_reg_b,
  output wire [FW-1:0] frac_ext_q,
  output wire [EW-1:0] scale_a,
  output wire [EW-1:0] scale_b,
  output wire sign_a,
  output wire sign_b,
  output wire [FW-1:0] alu_bus,
  output wire align_phase,
  output wire operate_phase,
  output wire ts_run,
  output wire skip_align,
  output wire select_a_shift,
  output wire busy,
  output wire done,
  output wire add_carry
);

  reg [`ST_W-1:0] state_q;
  reg [FW-1:0] frac_a_q;
  reg [FW-1:0] frac_b_q;
  reg [FW-1:0] frac_q_q;
  reg [EW-1:0] scale_a_q;
  reg [EW-1:0] scale_b_q;
  reg sign_a_q;
  reg sign_b_q;
  reg [1:0] op_q;
  reg round_q;
  reg skip_q;
  reg sel_a_q;
  reg a_zero_q;
  reg b_zero_q;
  reg big_gap_q;
  reg done_q;
  reg carry_q;
  reg [FW-1:0] bus_q;

  // ALU: A plus B, or A minus B minus one plus carry insert
  function [FW:0] alu;
    input a_en;
    input b_en;
    input [FW-1:0] a;
    input [FW-1:0] b;
    input sub;
    input cin;
    reg [FW-1:0] ea;
    reg [FW-1:0] eb;
    begin
      ea = a_en ? a : {FW{1'b0}};
      eb = b_en ? b : {FW{1'b0}};
      if (sub) begin
        alu = {1'b0, ea} + {1'b0, ~eb} + {{FW{1'b0}}, cin};
      end else begin
        alu = {1'b0, ea} + {1'b0, eb};
      end
    end
  endfunction

  // Reverse subtract decode, used at start and in the fetch step
  function is_rsub;
    input [1:0] code;
    begin
      is_rsub = (code == `OP_RSUB);
    end
  endfunction

  // One right shift; the spilled bit lands in the top of the extension
  function [2*FW-1:0] shr_spill;
    input [FW-1:0] frac;
    input [FW-1:0] ext;
    begin
      shr_spill = {1'b0, frac[FW-1:1], frac[0], ext[FW-1:1]};
    end
  endfunction

  // Magnitude of a signed difference one bit wider than the exponent
  function [EW:0] mag;
    input [EW:0] v;
    begin
      mag = v[EW] ? (~v + {{EW{1'b0}}, 1'b1}) : v;
    end
  endfunction

  // Sequencer states, one bit each
  localparam [`ST_W-1:0] S_IDLE = `ST_IDLE;
  localparam [`ST_W-1:0] S_FETCH = `ST_FETCH;
  localparam [`ST_W-1:0] S_ZCHK = `ST_ZCHK;
  localparam [`ST_W-1:0] S_DIFF = `ST_DIFF;
  localparam [`ST_W-1:0] S_ALIGN = `ST_ALIGN;
  localparam [`ST_W-1:0] S_OPER = `ST_OPER;
  localparam [`ST_W-1:0] S_FIX = `ST_FIX;

  // Zero tests driven through the ALU in subtract mode
  wire rsub_op = is_rsub(op_q);
  wire [FW:0] ztest = rsub_op ?
    alu(1'b1, 1'b0, frac_a_q, frac_b_q, 1'b1, 1'b0) :
    alu(1'b0, 1'b1, frac_a_q, frac_b_q, 1'b1, 1'b0);
  wire zero_hit = &ztest[FW-1:0];

  // Exponent difference and its sign
  wire [EW-1:0] diff = scale_a_q - scale_b_q;
  wire [EW-1:0] diff_m1 = diff - {{(EW-1){1'b0}}, 1'b1};
  wire scale_diff_sign = diff[EW-1];
  wire [EW:0] wide_diff = {scale_a_q[EW-1], scale_a_q} -
    {scale_b_q[EW-1], scale_b_q};
  wire [EW:0] gap_mag = mag(wide_diff);
  wire gap_big = (gap_mag > {{(EW+1-CW){1'b0}}, `GAP_LIMIT});
  wire scale_eq = &diff_m1;

  // Choice of the mantissa to shift from exponent signs
  wire sa_n = scale_a_q[EW-1];
  wire sb_n = scale_b_q[EW-1];
  wire pick_a = (~sa_n & ~sb_n & scale_diff_sign) | // RULE6
    (sa_n & sb_n & scale_diff_sign) | (sa_n & ~sb_n);

  // Counter set-up: the negative difference itself for A, counted up
  // to the carry; difference minus one for B, counted down to the borrow
  wire [CW-1:0] cnt_load_val = pick_a ? diff[CW-1:0] : // RULE7
    diff_m1[CW-1:0]; // RULE8

  // Shifted mantissa and extension for either side
  wire [2*FW-1:0] shr_a = shr_spill(frac_a_q, frac_q_q);
  wire [2*FW-1:0] shr_b = shr_spill(frac_b_q, frac_q_q);

  wire in_diff = state_q[3];
  wire in_align = state_q[4];
  wire in_oper = state_q[5];
  wire in_fix = state_q[6];
  wire cnt_load = in_diff & ~skip_q & ~gap_big & ~scale_eq;
  wire wrap_up;
  wire wrap_down;
  wire align_end = wrap_up | wrap_down;

  shift_counter #(
    .W(CW)
  ) u_shift_counter (
    .clock(clock),
    .rst(rst),
    .load(cnt_load),
    .load_value(cnt_load_val),
    .step(in_align),
    .count_up(sel_a_q),
    .count(),
    .count_wrap_up(wrap_up),
    .count_wrap_down(wrap_down)
  );

  // Operate-phase decisions
  wire like_signs = (sign_a_q == sign_b_q);
  wire eff_sub = (op_q == `OP_ADD) ? ~like_signs : like_signs; // RULE13
  wire a_side = ~a_zero_q & ~(big_gap_q & sel_a_q); // RULE11 RULE12
  wire b_side = ~b_zero_q & ~(big_gap_q & ~sel_a_q); // RULE11 RULE12
  wire rnd_ext = round_q & frac_q_q[FW-1];
  wire carry_ins = eff_sub & ~(~sel_a_q & rnd_ext); // RULE14
  wire [FW:0] oper_res = alu(a_side, b_side, frac_a_q, frac_b_q,
    eff_sub, carry_ins);
  wire sub_ovf = eff_sub & ~oper_res[FW];
  wire [FW-1:0] fix_val = ~frac_a_q + {{(FW-1){1'b0}}, 1'b1} +
    {{(FW-1){1'b0}}, ~rnd_ext}; // RULE15 RULE16

  assign frac_acc_a = frac_a_q;
  assign frac_reg_b = frac_b_q;
  assign frac_ext_q = frac_q_q;
  assign scale_a = scale_a_q;
  assign scale_b = scale_b_q;
  assign sign_a = sign_a_q;
  assign sign_b = sign_b_q;
  assign alu_bus = bus_q;
  assign align_phase = state_q[2] | state_q[3] | state_q[4];
  assign operate_phase = in_oper | in_fix;
  assign ts_run = ~in_align; // RULE10
  assign skip_align = skip_q;
  assign select_a_shift = sel_a_q;
  assign busy = ~state_q[0];
  assign done = done_q;
  assign add_carry = carry_q;

  always @(posedge clock) begin
    if (rst) begin
      state_q <= `ST_IDLE;
      frac_a_q <= {FW{1'b0}};
      frac_b_q <= {FW{1'b0}};
      frac_q_q <= {FW{1'b0}};
      scale_a_q <= {EW{1'b0}};
      scale_b_q <= {EW{1'b0}};
      sign_a_q <= 1'b0;
      sign_b_q <= 1'b0;
      op_q <= `OP_ADD;
      round_q <= 1'b0;
      skip_q <= 1'b0;
      sel_a_q <= 1'b0;
      a_zero_q <= 1'b0;
      b_zero_q <= 1'b0;
      big_gap_q <= 1'b0;
      done_q <= 1'b0;
      carry_q <= 1'b0;
      bus_q <= {FW{1'b0}};
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            op_q <= op;
            round_q <= instr_word[`RND_BIT]; // RULE17
            carry_q <= 1'b0;
            state_q <= `ST_FETCH;
            if (is_rsub(op)) begin
              // Accumulator moves to the B side first
              frac_b_q <= frac_a_q; // RULE18
              scale_b_q <= scale_a_q; // RULE18
              sign_b_q <= sign_a_q; // RULE18
            end else begin
              frac_b_q <= op_frac;
              scale_b_q <= op_scale;
              sign_b_q <= op_sign;
            end
          end else if (load_acc) begin
            frac_a_q <= op_frac;
            scale_a_q <= op_scale;
            sign_a_q <= op_sign;
          end
        end
        S_FETCH: begin
          if (rsub_op) begin
            frac_a_q <= op_frac; // RULE18
            scale_a_q <= op_scale;
            sign_a_q <= op_sign;
          end
          frac_q_q <= {FW{1'b0}};
          skip_q <= 1'b0; // RULE19
          a_zero_q <= 1'b0;
          b_zero_q <= 1'b0;
          big_gap_q <= 1'b0;
          sel_a_q <= 1'b0;
          state_q <= `ST_ZCHK;
        end
        S_ZCHK: begin
          bus_q <= ztest[FW-1:0];
          if (zero_hit) begin
            skip_q <= 1'b1; // RULE1 RULE2
            if (rsub_op) begin
              a_zero_q <= 1'b1; // RULE1
            end else begin
              b_zero_q <= 1'b1; // RULE2
            end
          end
          state_q <= `ST_DIFF;
        end
        S_DIFF: begin
          bus_q <= {{(FW-EW){diff_m1[EW-1]}}, diff_m1}; // RULE4
          sel_a_q <= pick_a; // RULE5 RULE6
          big_gap_q <= gap_big; // RULE12
          if (skip_q) begin
            state_q <= `ST_OPER;
          end else if (gap_big) begin
            skip_q <= 1'b1; // RULE3
            state_q <= `ST_OPER;
          end else if (scale_eq) begin
            state_q <= `ST_OPER; // RULE4
          end else begin
            if (pick_a) begin
              scale_a_q <= scale_b_q; // RULE9
            end
            state_q <= `ST_ALIGN;
          end
        end
        S_ALIGN: begin
          // Right shift with the spilled bit entering the extension
          if (sel_a_q) begin
            frac_a_q <= shr_a[2*FW-1:FW];
            frac_q_q <= shr_a[FW-1:0];
          end else begin
            frac_b_q <= shr_b[2*FW-1:FW];
            frac_q_q <= shr_b[FW-1:0];
          end
          if (align_end) begin
            state_q <= `ST_OPER; // RULE7 RULE8 RULE10
          end
        end
        S_OPER: begin
          bus_q <= oper_res[FW-1:0];
          frac_a_q <= oper_res[FW-1:0]; // RULE14
          carry_q <= ~eff_sub & oper_res[FW];
          if (sub_ovf) begin
            state_q <= `ST_FIX;
          end else begin
            done_q <= 1'b1;
            state_q <= `ST_IDLE;
          end
        end
        S_FIX: begin
          sign_a_q <= ~sign_a_q; // RULE15
          frac_a_q <= fix_val; // RULE15 RULE16
          bus_q <= fix_val;
          done_q <= 1'b1;
          state_q <= `ST_IDLE;
        end
        default: begin
          state_q <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule // fp_add_sub_align

`default_nettype wire

// ==== core/fp_align_defines.vh ====
// Constants for the floating-point add/subtract alignment datapath.
// Included by bare name from every design file of the block.
`ifndef FP_ALIGN_DEFINES_VH
`define FP_ALIGN_DEFINES_VH

// Operand and shift counter widths
`define FRAC_W 35
`define SCALE_W 18
`define CNT_W 6

// Operation codes on the op port
`define OP_ADD 2'h0
`define OP_SUB 2'h1
`define OP_RSUB 2'h2

// Exponent gap beyond which the smaller operand counts as zero
`define GAP_LIMIT 6'h23

// Instruction word: width and index of the rounding request bit
`define INSTR_W 18
`define RND_BIT 14

// One-hot sequencer states
`define ST_W 7
`define ST_IDLE 7'h01
`define ST_FETCH 7'h02
`define ST_ZCHK 7'h04
`define ST_DIFF 7'h08
`define ST_ALIGN 7'h10
`define ST_OPER 7'h20
`define ST_FIX 7'h40

`endif

// ==== core/shift_counter.v ====
// Up/down shift counter with carry and borrow detection.
// Assumes a synchronous active-high reset on the shared clock.
`timescale 1ns/1ps
`default_nettype none
`include "fp_align_defines.vh"

module shift_counter #(
  parameter W = `CNT_W
) (
  input wire clock,
  input wire rst,
  input wire load,
  input wire [W-1:0] load_value,
  input wire step,
  input wire count_up,
  output wire [W-1:0] count,
  output wire count_wrap_up,
  output wire count_wrap_down
);

  reg [W-1:0] count_q;

  assign count = count_q;
  // Carry: all ones stepping up; borrow: all zeros stepping down
  assign count_wrap_up = step & count_up & (&count_q);
  assign count_wrap_down = step & ~count_up & ~(|count_q);

  always @(posedge clock) begin
    if (rst) begin
      count_q <= {W{1'b0}};
    end else if (load) begin
      count_q <= load_value;
    end else if (step) begin
      if (count_up) begin
        count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
      end else begin
        count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // shift_counter

`default_nettype wire

// ==== sim/fp_add_sub_align_bench.sv ====
// Self-checking bench for the add/subtract alignment block.
// Assumes the block's defines header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "fp_align_defines.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module fp_add_sub_align_bench;
  logic clock = 0, rst = 1, load_acc = 0, start = 0, op_sign = 0;
  logic [1:0] op = 0;
  logic [`INSTR_W-1:0] instr_word = 0;
  logic [`SCALE_W-1:0] op_scale = 0, scale_a, scale_b, e1, e2;
  logic [`FRAC_W-1:0] op_frac = 0, frac_acc_a, frac_reg_b, frac_ext_q;
  logic [`FRAC_W-1:0] alu_bus;
  logic sign_a, sign_b, done, add_carry;
  logic [143:0] exp_q[$];
  logic [143:0] exp_now;
  int bad_count = 0, n_tests = 0;
  fp_add_sub_align u_fp_add_sub_align (.clock, .rst, .load_acc, .start,
    .op, .instr_word, .op_sign, .op_scale, .op_frac, .frac_acc_a,
    .frac_reg_b, .frac_ext_q, .scale_a, .scale_b, .sign_a,
    .sign_b, .alu_bus, .align_phase(), .operate_phase(), .ts_run(),
    .skip_align(), .select_a_shift(), .busy(), .done, .add_carry);
  always #25 clock = ~clock;
  // Reference {extension, carry, B side, A side} from the two sides
  function automatic [143:0] model(input [1:0] o, input r, input sa, sb,
      input [17:0] ea, eb, input [34:0] fa, fb);
    int d;
    logic [35:0] t;
    logic [34:0] ua, ub, q;
    logic ext, bs, es, z, cy;
    d = $signed(ea) - $signed(eb);
    ext = 0;
    bs = 0;
    q = 0;
    z = (o == `OP_RSUB) ? fa == 0 : fb == 0;
    if (!z && d < 0 && d >= -35) begin
      ext = fa[-d-1];
      q = fa << (35 + d);
      fa = fa >> -d;
      ea = eb;
    end else if (!z && d > 0 && d <= 35) begin
      ext = fb[d-1];
      q = fb << (35 - d);
      fb = fb >> d;
      bs = 1;
    end
    // Far smaller operand counts as zero on its ALU side
    ua = (d < -35) ? 35'h0 : fa;
    ub = (d > 35) ? 35'h0 : fb;
    es = (o == `OP_ADD) ? sa != sb : sa == sb;
    if (!es) t = ua + ub;
    else t = {1'b0, ua} + {1'b0, ~ub} + !(bs && r && ext);
    cy = !es && t[35];
    if (es && !t[35]) begin
      t[34:0] = ~t[34:0] + 35'h1 + !(r && ext);
      sa = !sa;
    end
    return {q, cy, sb, eb, fb, sa, ea, t[34:0]};
  endfunction
  task automatic run(input [1:0] o, input r, input sa, input [17:0] ea,
      input [34:0] fa, input sb, input [17:0] eb, input [34:0] fb);
    int k;
    @(posedge clock); #5;
    load_acc = 1; {op_sign, op_scale, op_frac} = {sa, ea, fa};
    @(posedge clock); #5;
    load_acc = 0; start = 1; op = o;
    instr_word = 18'($urandom);
    instr_word[`RND_BIT] = r;
    {op_sign, op_scale, op_frac} = {sb, eb, fb};
    if (o == `OP_RSUB) exp_q.push_back(model(o, r, sb, sa, eb, ea, fb, fa));
    else exp_q.push_back(model(o, r, sa, sb, ea, eb, fa, fb));
    @(posedge clock); #5;
    start = 0;
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(posedge clock); #5; k++;
    end
    if (k == 60) begin
      bad_count++;
      wrap_up;
    end
  endtask
  always @(negedge clock) if (done === 1'b1) begin
    if (exp_q.size() == 0) bad_count++;
    else begin
      exp_now = exp_q.pop_front();
      `CHK("result", exp_now[53:0], {sign_a, scale_a, frac_acc_a})
      `CHK("alu bus", exp_now[34:0], alu_bus)
      `CHK("b side", exp_now[107:54], {sign_b, scale_b, frac_reg_b})
      `CHK("add carry", exp_now[108], add_carry)
      `CHK("extension", exp_now[143:109], frac_ext_q)
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(50547));
    repeat (16) @(posedge clock);
    #5 rst = 0;
    run(`OP_ADD, 1'h0, 1'h0, 18'h3, 35'h100, 1'h0, 18'h1, 35'h5);
    run(`OP_ADD, 1'h0, 1'h0, 18'h2, 35'h90, 1'h1, 18'h0, 35'h9);
    run(`OP_SUB, 1'h0, 1'h1, 18'h4, 35'h3, 1'h1, 18'h4, 35'h6);
    run(`OP_SUB, 1'h1, 1'h0, 18'h1, 35'h10, 1'h0, 18'h0, 35'h3);
    run(`OP_SUB, 1'h1, 1'h0, 18'h1, 35'h1, 1'h0, 18'h0, 35'h7);
    run(`OP_ADD, 1'h0, 1'h0, 18'h2, 35'h10, 1'h0, 18'h4, 35'h1);
    run(`OP_ADD, 1'h0, 1'h0, 18'h3fffb, 35'h40, 1'h0, 18'h3fffd, 35'h1);
    run(`OP_ADD, 1'h0, 1'h0, 18'h3fffb, 35'h80, 1'h0, 18'h2, 35'h1);
    run(`OP_SUB, 1'h0, 1'h0, 18'h3, 35'h40, 1'h1, 18'h3fffe, 35'h8);
    run(`OP_RSUB, 1'h0, 1'h0, 18'h3, 35'h20, 1'h0, 18'h1, 35'h8);
    run(`OP_RSUB, 1'h0, 1'h1, 18'h7, 35'h20, 1'h1, 18'h1, 35'h0);
    run(`OP_ADD, 1'h0, 1'h0, 18'h1, 35'h33, 1'h0, 18'h5, 35'h0);
    run(`OP_ADD, 1'h0, 1'h0, 18'h24, 35'h77, 1'h0, 18'h0, 35'hfff);
    run(`OP_SUB, 1'h1, 1'h0, 18'h23, 35'h10, 1'h0, 18'h0, 35'h400000000);
    for (int i = 0; i < 30; i++) begin
      e1 = 18'($urandom_range(40)) - 18'h14;
      e2 = 18'($urandom_range(40)) - 18'h14;
      run(2'($urandom_range(2)), 1'($urandom), 1'($urandom), e1,
        {3'h0, $urandom}, 1'($urandom), e2, {$urandom, 3'h5});
    end
    repeat (3) @(posedge clock);
    `CHK("pending", 0, exp_q.size())
    wrap_up;
  end
endmodule // fp_add_sub_align_bench
`default_nettype wire

// ==== sim/fp_align_asserts.sv ====
// Concurrent checks on the add/subtract alignment block's ports.
// Assumes one clock and the synchronous active-high reset rst.
`timescale 1ns/1ps
`default_nettype none
module fp_align_asserts #(
  parameter EW = 18
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic busy,
  input wire logic done,
  input wire logic ts_run,
  input wire logic align_phase,
  input wire logic operate_phase,
  input wire logic skip_align,
  input wire logic select_a_shift,
  input wire logic [EW-1:0] scale_a,
  input wire logic [EW-1:0] scale_b,
  input wire logic sign_a
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_skip_cleared: assert property (
    $rose(busy) |=> !skip_align) else $error("skip flag left set");
  a_done_bound: assert property (
    $rose(busy) |-> ##[4:41] done) else $error("no done in time");
  a_stop_shift: assert property (
    !ts_run |-> align_phase && !skip_align) else $error("bad stop");
  a_restart_op: assert property (
    align_phase && !ts_run ##1 !align_phase |-> ts_run && operate_phase)
    else $error("no restart after align");
  a_shift_bound: assert property (
    $fell(ts_run) |-> ##[1:35] ts_run) else $error("shift too long");
  a_scale_copy: assert property (
    !ts_run && select_a_shift |-> scale_a == scale_b)
    else $error("exponent not copied");
  a_fix_sign: assert property (
    operate_phase ##1 operate_phase |=> sign_a != $past(sign_a, 2))
    else $error("sign not flipped");
  a_done_pulse: assert property (
    done |-> (!busy && $past(operate_phase)) ##1 !done)
    else $error("bad done pulse");
  cover property (select_a_shift && !ts_run);
  cover property (operate_phase ##1 operate_phase);
  cover property (skip_align && operate_phase);
endmodule // fp_align_asserts

bind fp_add_sub_align fp_align_asserts #(.EW(EW)) u_fp_align_asserts (
  .clock, .rst, .busy, .done, .ts_run, .align_phase, .operate_phase,
  .skip_align, .select_a_shift, .scale_a, .scale_b, .sign_a);
`default_nettype wire
